// ===== design/ppts_port_ptp_regs.sv
// per-port ptp latency, asymmetry and egress timestamp register bank
// Notes on behaviour
// - rx latency, 16 bits rw, resets 415, offered to receive stamping as wire delay
// - tx latency, 16 bits rw, resets 45, offered to transmit stamping as wire delay
// - asymmetry is sign-magnitude: bit 15 negative, bits 14:0 magnitude, reset zero
// - ingress sync and response messages add signed asymmetry to correction field
// - egress request messages subtract signed asymmetry from correction field
// - request egress stamp captured, read as high and low read-only words, reset zero
// - sync egress stamp captured separately, high and low read-only words, reset zero
// - response egress stamp captured separately, high and low read-only words, reset zero
// - status bit 15 sets on sync stamp, write one clears, resets zero
// - status bit 14 sets on request stamp, write one clears
// - status bit 13 sets on response stamp, write one clears
// - the three status bits are ored into the port ptp interrupt status
// - allow bits 15..13 gate each interrupt; their or is port ptp interrupt enable
`timescale 1ns/10ps
`default_nettype none
module ppts_port_ptp_regs #(
	parameter int CORR_WIDTH = ppts_pkg::CORR_W
) (
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	input  wire ppts_pkg::ppts_bus_req_s busReq,
	output logic [15:0]                 busReadData,
	output logic                        busReadValid,
	input  wire ppts_pkg::ppts_capture_s capture,
	input  wire ppts_pkg::ppts_corr_req_s corrReq,
	output logic [CORR_WIDTH-1:0]       corrField,
	output logic                        corrValid,
	output logic [15:0]                 rxPathLatencyNs,
	output logic [15:0]                 txPathLatencyNs,
	output logic                        ptpIrqStatus,
	output logic                        ptpIrqEnable,
	output logic                        ptpIrq
);
	ppts_pkg::ppts_state_s state;
	ppts_pkg::ppts_state_s next_state;

	// signed asymmetry, sign-magnitude converted to two's complement at field width
	function automatic logic [CORR_WIDTH-1:0] asymSigned(input logic [15:0] asym);
		logic [CORR_WIDTH-1:0] mag;
		mag = CORR_WIDTH'(asym[ppts_pkg::ASYM_SIGN_BIT-1:0]);
		asymSigned = asym[ppts_pkg::ASYM_SIGN_BIT] ? (~mag + CORR_WIDTH'(1)) : mag;
	endfunction

	// status word position of each flag, flag index 0 sync, 1 request, 2 response
	function automatic logic [15:0] flagsToWord(input logic [2:0] f);
		flagsToWord = '0;
		flagsToWord[ppts_pkg::BIT_SYNC] = f[0];
		flagsToWord[ppts_pkg::BIT_REQ]  = f[1];
		flagsToWord[ppts_pkg::BIT_RESP] = f[2];
	endfunction

	function automatic logic [2:0] wordToFlags(input logic [15:0] w);
		wordToFlags = {w[ppts_pkg::BIT_RESP], w[ppts_pkg::BIT_REQ], w[ppts_pkg::BIT_SYNC]};
	endfunction

	logic [2:0] setFlags;
	logic [2:0] clearFlags;
	logic       wrHit;

	always_comb begin
		next_state = state;
		next_state.readValid = 1'b0;
		next_state.corrValid = 1'b0;
		setFlags = '0;
		wrHit = busReq.write;
		clearFlags = '0;

		// register writes
		if (wrHit) begin
			unique case (busReq.addr)
				ppts_pkg::OFF_RX_LAT: begin
					next_state.rxLatency = busReq.wdata;
				end
				ppts_pkg::OFF_TX_LAT: begin
					next_state.txLatency = busReq.wdata;
				end
				ppts_pkg::OFF_ASYM: begin
					next_state.asymmetry = busReq.wdata;
				end
				ppts_pkg::OFF_STATUS: begin
					clearFlags = wordToFlags(busReq.wdata);
				end
				ppts_pkg::OFF_ALLOW: begin
					next_state.irqAllow = wordToFlags(busReq.wdata);
				end
				default: begin
				end
			endcase
		end

		// capture loads both words in the same cycle as the flag sets
		if (capture.valid) begin
			unique case (capture.kind)
				ppts_pkg::PPTS_MSG_SYNC: begin
					next_state.syncStamp = capture.stamp;
					setFlags[0] = 1'b1;
				end
				ppts_pkg::PPTS_MSG_REQ: begin
					next_state.requestStamp = capture.stamp;
					setFlags[1] = 1'b1;
				end
				ppts_pkg::PPTS_MSG_RESP: begin
					next_state.responseStamp = capture.stamp;
					setFlags[2] = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// set wins over a simultaneous write-one clear so no stamp event is lost
		next_state.readyFlags = (state.readyFlags & ~clearFlags) | setFlags;

		// register reads, answered one cycle later; unmapped offsets read zero
		if (busReq.read) begin
			next_state.readValid = 1'b1;
			unique case (busReq.addr)
				ppts_pkg::OFF_RX_LAT:    next_state.readData = state.rxLatency;
				ppts_pkg::OFF_TX_LAT:    next_state.readData = state.txLatency;
				ppts_pkg::OFF_ASYM:      next_state.readData = state.asymmetry;
				ppts_pkg::OFF_REQ_HIGH:  next_state.readData = state.requestStamp[31:16];
				ppts_pkg::OFF_REQ_LOW:   next_state.readData = state.requestStamp[15:0];
				ppts_pkg::OFF_SYNC_HIGH: next_state.readData = state.syncStamp[31:16];
				ppts_pkg::OFF_SYNC_LOW:  next_state.readData = state.syncStamp[15:0];
				ppts_pkg::OFF_RESP_HIGH: next_state.readData = state.responseStamp[31:16];
				ppts_pkg::OFF_RESP_LOW:  next_state.readData = state.responseStamp[15:0];
				ppts_pkg::OFF_STATUS:    next_state.readData = flagsToWord(state.readyFlags);
				ppts_pkg::OFF_ALLOW:     next_state.readData = flagsToWord(state.irqAllow);
				default:                 next_state.readData = ppts_pkg::RST_ZERO;
			endcase
		end

		// correction field update uses the asymmetry in force at request time
		if (corrReq.valid) begin
			next_state.corrValid = 1'b1;
			next_state.corrOut = corrReq.field;
			if (!corrReq.egress && (corrReq.kind == ppts_pkg::PPTS_MSG_SYNC
					|| corrReq.kind == ppts_pkg::PPTS_MSG_RESP)) begin
				next_state.corrOut = corrReq.field + asymSigned(state.asymmetry);
			end else if (corrReq.egress && corrReq.kind == ppts_pkg::PPTS_MSG_REQ) begin
				next_state.corrOut = corrReq.field - asymSigned(state.asymmetry);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state.rxLatency     <= ppts_pkg::RST_RX_LAT;
			state.txLatency     <= ppts_pkg::RST_TX_LAT;
			state.asymmetry     <= ppts_pkg::RST_ASYM;
			state.requestStamp  <= '0;
			state.syncStamp     <= '0;
			state.responseStamp <= '0;
			state.readyFlags    <= '0;
			state.irqAllow      <= '0;
			state.readData      <= ppts_pkg::RST_ZERO;
			state.readValid     <= 1'b0;
			state.corrOut       <= '0;
			state.corrValid     <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign busReadData     = state.readData;
	assign busReadValid    = state.readValid;
	assign corrField       = state.corrOut;
	assign corrValid       = state.corrValid;
	assign rxPathLatencyNs = state.rxLatency;
	assign txPathLatencyNs = state.txLatency;
	assign ptpIrqStatus    = |state.readyFlags;
	assign ptpIrqEnable    = |state.irqAllow;
	// each flag passes only when its own allow bit is set
	assign ptpIrq          = |(state.readyFlags & state.irqAllow);
endmodule
`default_nettype wire

// ===== design/ppts_pkg.sv
// package for the per-port ptp timestamp register bank
package ppts_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int CORR_W = 32;

	localparam logic [15:0] OFF_RX_LAT      = 16'h0C00;
	localparam logic [15:0] OFF_TX_LAT      = 16'h0C02;
	localparam logic [15:0] OFF_ASYM        = 16'h0C04;
	localparam logic [15:0] OFF_REQ_HIGH    = 16'h0C08;
	localparam logic [15:0] OFF_REQ_LOW     = 16'h0C0A;
	localparam logic [15:0] OFF_SYNC_HIGH   = 16'h0C0C;
	localparam logic [15:0] OFF_SYNC_LOW    = 16'h0C0E;
	localparam logic [15:0] OFF_RESP_HIGH   = 16'h0C10;
	localparam logic [15:0] OFF_RESP_LOW    = 16'h0C12;
	localparam logic [15:0] OFF_STATUS      = 16'h0C14;
	localparam logic [15:0] OFF_ALLOW       = 16'h0C16;

	localparam logic [15:0] RST_RX_LAT = 16'h019F;
	localparam logic [15:0] RST_TX_LAT = 16'h002D;
	localparam logic [15:0] RST_ASYM   = 16'h0000;
	localparam logic [15:0] RST_ZERO   = 16'h0000;

	localparam int ASYM_SIGN_BIT = 15;
	localparam int BIT_SYNC      = 15;
	localparam int BIT_REQ       = 14;
	localparam int BIT_RESP      = 13;

	// message kinds as carried on the timestamping datapath
	typedef enum logic [1:0] {
		PPTS_MSG_SYNC = 2'b00,
		PPTS_MSG_REQ  = 2'b01,
		PPTS_MSG_RESP = 2'b10,
		PPTS_MSG_NONE = 2'b11
	} ppts_msg_e;

	// register bus request
	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ppts_bus_req_s;

	// egress capture strobe
	typedef struct packed {
		logic        valid;
		ppts_msg_e   kind;
		logic [31:0] stamp;
	} ppts_capture_s;

	// correction field request from the datapath
	typedef struct packed {
		logic              valid;
		logic              egress;
		ppts_msg_e         kind;
		logic [CORR_W-1:0] field;
	} ppts_corr_req_s;

	typedef struct packed {
		logic [15:0]       rxLatency;
		logic [15:0]       txLatency;
		logic [15:0]       asymmetry;
		logic [31:0]       requestStamp;
		logic [31:0]       syncStamp;
		logic [31:0]       responseStamp;
		logic [2:0]        readyFlags;
		logic [2:0]        irqAllow;
		logic [15:0]       readData;
		logic              readValid;
		logic [CORR_W-1:0] corrOut;
		logic              corrValid;
	} ppts_state_s;
endpackage

// ===== testbench/ppts_checker.sv
// port assertions for the per-port ptp register bank
`timescale 1ns/10ps
`default_nettype none
module ppts_checker #(
	parameter int CORR_WIDTH = 32
) (
	input wire logic                     sys_clk,
	input wire logic                     reset_n,
	input wire ppts_pkg::ppts_bus_req_s  busReq,
	input wire logic [15:0]              busReadData,
	input wire logic                     busReadValid,
	input wire ppts_pkg::ppts_capture_s  capture,
	input wire ppts_pkg::ppts_corr_req_s corrReq,
	input wire logic [CORR_WIDTH-1:0]    corrField,
	input wire logic                     corrValid,
	input wire logic [15:0]              rxPathLatencyNs,
	input wire logic [15:0]              txPathLatencyNs,
	input wire logic                     ptpIrqStatus,
	input wire logic                     ptpIrqEnable,
	input wire logic                     ptpIrq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	AST_RX_LAT: assert property (busReq.write && busReq.addr == 16'h0C00
		|=> rxPathLatencyNs == $past(busReq.wdata)) else $error("rx latency write lost");
	AST_TX_LAT: assert property (busReq.write && busReq.addr == 16'h0C02
		|=> txPathLatencyNs == $past(busReq.wdata)) else $error("tx latency write lost");
	AST_SYNC_SET: assert property (capture.valid && capture.kind == 2'h0
		|=> ptpIrqStatus) else $error("sync capture raised no status");
	AST_CLEAR: assert property ($fell(ptpIrqStatus)
		|-> $past(busReq.write && busReq.addr == 16'h0C14)) else $error("status fell unasked");
	AST_HOLD: assert property (ptpIrqStatus && !busReq.write
		|=> ptpIrqStatus) else $error("status dropped without write");
	AST_CORR_VALID: assert property (corrReq.valid
		|=> corrValid) else $error("correction answer missing");
	AST_CORR_PASS: assert property (corrReq.valid && corrReq.kind == 2'h3
		|=> corrField == $past(corrReq.field)) else $error("correction altered");
	AST_RESERVED: assert property (busReq.read && busReq.addr == 16'h0C14
		|=> busReadData[12:0] == 13'h0000) else $error("reserved status bits set");
	AST_IRQ: assert property (ptpIrq |-> ptpIrqStatus && ptpIrqEnable)
		else $error("interrupt without status and allow");
endmodule
`default_nettype wire

// ===== testbench/test_port_ptp_timestamp_regs.sv
// self-checking bench for the per-port ptp register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module test_port_ptp_timestamp_regs;
	logic                     sys_clk = 0;
	logic                     reset_n = 0;
	ppts_pkg::ppts_bus_req_s  busReq  = '0;
	ppts_pkg::ppts_capture_s  capture = '0;
	ppts_pkg::ppts_corr_req_s corrReq = '0;
	logic [15:0]              busReadData, rxPathLatencyNs, txPathLatencyNs;
	logic [31:0]              corrField;
	logic                     busReadValid, corrValid, ptpIrqStatus, ptpIrqEnable, ptpIrq;
	int                       error_cnt = 0;
	int                       num_checks = 0;
	always #50 sys_clk = ~sys_clk;
	ppts_port_ptp_regs dut (.*);
	task automatic wr(input logic [15:0] a, d);
		@(posedge sys_clk) busReq <= '{1'b0, 1'b1, a, d};
		@(posedge sys_clk) busReq <= '0;
	endtask
	task automatic rd(input logic [15:0] a, e);
		@(posedge sys_clk) busReq <= '{1'b1, 1'b0, a, 16'h0000};
		@(posedge sys_clk) busReq <= '0;
		@(negedge sys_clk) `CHK("read valid", 1'b1, busReadValid)
		`CHK("read data", e, busReadData)
	endtask
	task automatic cap(input logic [1:0] k, input logic [31:0] s);
		@(posedge sys_clk) capture <= '{1'b1, ppts_pkg::ppts_msg_e'(k), s};
		@(posedge sys_clk) capture <= '0;
	endtask
	task automatic cr(input logic eg, input logic [1:0] k, input logic [31:0] f, e);
		@(posedge sys_clk) corrReq <= '{1'b1, eg, ppts_pkg::ppts_msg_e'(k), f};
		@(posedge sys_clk) corrReq <= '0;
		@(negedge sys_clk) `CHK("corr valid", 1'b1, corrValid)
		`CHK("corr field", e, corrField)
	endtask
	task automatic t_reset;
		rd(16'h0C00, 16'h019F);
		rd(16'h0C02, 16'h002D);
		rd(16'h0C04, 16'h0000);
		for (int a = 'h0C08; a <= 'h0C14; a += 2) rd(a[15:0], 16'h0000);
	endtask
	task automatic t_regs;
		wr(16'h0C00, 16'hBEEF);
		wr(16'h0C02, 16'h1234);
		wr(16'h0C04, 16'hFFFF);
		rd(16'h0C00, 16'hBEEF);
		`CHK("rx port", 16'hBEEF, rxPathLatencyNs)
		`CHK("tx port", 16'h1234, txPathLatencyNs)
		rd(16'h0C04, 16'hFFFF);
		wr(16'h0C08, 16'hAAAA);
		rd(16'h0C08, 16'h0000);
		wr(16'h0C14, 16'h1FFF);
		rd(16'h0C14, 16'h0000);
		rd(16'h0C06, 16'h0000);
	endtask
	task automatic t_stamps;
		cap(2'h0, 32'h1111_2222);
		cap(2'h0, 32'hA5A5_5A5A);
		rd(16'h0C14, 16'h8000);
		`CHK("irq status", 1'b1, ptpIrqStatus)
		rd(16'h0C0C, 16'hA5A5);
		rd(16'h0C0E, 16'h5A5A);
		cap(2'h1, 32'h0102_0304);
		cap(2'h2, 32'hF0E0_D0C0);
		cap(2'h3, 32'hFFFF_FFFF);
		rd(16'h0C14, 16'hE000);
		rd(16'h0C08, 16'h0102);
		rd(16'h0C0A, 16'h0304);
		rd(16'h0C10, 16'hF0E0);
		rd(16'h0C12, 16'hD0C0);
		wr(16'h0C14, 16'h4000);
		rd(16'h0C14, 16'hA000);
		wr(16'h0C14, 16'hA000);
		rd(16'h0C14, 16'h0000);
		`CHK("irq status", 1'b0, ptpIrqStatus)
	endtask
	task automatic t_irq;
		wr(16'h0C16, 16'h2000);
		rd(16'h0C16, 16'h2000);
		`CHK("irq enable", 1'b1, ptpIrqEnable)
		cap(2'h0, 32'h0000_0001);
		rd(16'h0C14, 16'h8000);
		`CHK("irq masked", 1'b0, ptpIrq)
		cap(2'h2, 32'h0000_0002);
		rd(16'h0C14, 16'hA000);
		`CHK("irq raised", 1'b1, ptpIrq)
		wr(16'h0C14, 16'hA000);
		wr(16'h0C16, 16'h0000);
		rd(16'h0C16, 16'h0000);
		`CHK("irq enable", 1'b0, ptpIrqEnable)
	endtask
	task automatic t_corr;
		wr(16'h0C04, 16'h8005);
		cr(1'b0, 2'h0, 32'h0000_0064, 32'h0000_005F);
		cr(1'b0, 2'h2, 32'h0000_0064, 32'h0000_005F);
		cr(1'b1, 2'h1, 32'h0000_0064, 32'h0000_0069);
		cr(1'b1, 2'h0, 32'h0000_0064, 32'h0000_0064);
		cr(1'b0, 2'h1, 32'h0000_0064, 32'h0000_0064);
		wr(16'h0C04, 16'h0005);
		cr(1'b0, 2'h0, 32'h0000_0064, 32'h0000_0069);
		cr(1'b1, 2'h1, 32'h0000_0064, 32'h0000_005F);
		cr(1'b0, 2'h3, 32'h0000_0064, 32'h0000_0064);
	endtask
	// a mid-run reset must bring back every default up to the status word over values written since
	task automatic t_rerun_reset;
		@(posedge sys_clk) reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_reset();
	endtask
	task automatic stop_test;
		if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// the bench has no open waits, so one watchdog bounds the whole run
	initial begin
		#2000000;
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_reset();
		t_regs();
		t_stamps();
		t_irq();
		t_corr();
		t_rerun_reset();
		stop_test();
	end
endmodule
bind ppts_port_ptp_regs ppts_checker #(.CORR_WIDTH(CORR_WIDTH)) chk (.*);
`default_nettype wire
